// *** core/bts_cfg.svh ***
// constants for the bit-test-and-skip execution block
`ifndef BTS_CFG_SVH
`define BTS_CFG_SVH
`define BTS_OP_W        12
`define BTS_OPC_HI      11
`define BTS_OPC_LO      8
`define BTS_OPC_CLEAR   4'h6
`define BTS_OPC_SET     4'h7
`define BTS_BIT_HI      7
`define BTS_BIT_LO      5
`define BTS_REG_HI      4
`define BTS_REG_LO      0
`define BTS_REG_AW      5
`define BTS_DATA_W      8
`define BTS_BIT_AW      3
`define BTS_NOP_WORD    12'h000
`define BTS_SKIP_CYCLES 2
`endif

// *** core/bts_pkg.sv ***
// types shared by the bit-test-and-skip block
`include "bts_cfg.svh"
package bts_pkg;
  // execution state: normal issue or a discarded slot
  typedef enum logic [0:0]
  {
    BTS_RUN  = 1'h0,
    BTS_SKIP = 1'h1
  } bts_state_e;
  // decoded class of the word in execute
  typedef enum logic [1:0]
  {
    BTS_OTHER = 2'h0,
    BTS_CLEAR = 2'h1,
    BTS_SET   = 2'h2
  } bts_kind_e;
endpackage : bts_pkg

// *** core/bts_rd_if.sv ***
// file register read path between the decoder and the bit tester
`timescale 1ns/100ps
`include "bts_cfg.svh"
interface bts_rd_if;
  logic [`BTS_DATA_W-1:0] rd_data;  // addressed register contents
  logic [`BTS_BIT_AW-1:0] bit_sel;  // selected bit position
  logic                   bit_val;  // selected bit value
  modport tester (input rd_data, input bit_sel, output bit_val);
  modport core   (output rd_data, output bit_sel, input bit_val);
endinterface : bts_rd_if

// *** core/bts_bit_sel.sv ***
// picks one bit out of a file register word
`timescale 1ns/100ps
`include "bts_cfg.svh"
module bts_bit_sel
(
  bts_rd_if.tester rd
);
  // ----------------------------------------
  // bit select
  // ----------------------------------------
  // plain mux; eight positions cover the whole byte
  assign rd.bit_val = rd.rd_data[rd.bit_sel]; // RL5
endmodule : bts_bit_sel

// *** core/bts_core.sv ***
// execution of the bit-test-and-skip instructions
// ----------------------------------------
// Overview of operation
// (RL1) skip next word when tested bit clear
// (RL2) skip next word when tested bit set
// (RL3) skip discards prefetched word, runs no-op
// (RL4) one word; one cycle, two if skipping
// (RL5) register 0..31, bit 0..7 selectable
// (RL6) decode 0110/0111 patterns; flags untouched
// ----------------------------------------
`timescale 1ns/100ps
`include "bts_cfg.svh"
module bts_core
#(
  parameter int OP_W = `BTS_OP_W  // instruction word width
)
(
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   instr_valid,
  input  wire logic [OP_W-1:0]        instr_word,
  input  wire logic [`BTS_DATA_W-1:0] reg_rd_data,
  output logic [`BTS_REG_AW-1:0]      reg_rd_addr,
  output logic                        exec_valid,
  output logic [OP_W-1:0]             exec_word,
  output logic                        skip_taken,
  output logic                        flags_we
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (OP_W != `BTS_OP_W)
  begin : g_chk
    $error("instruction width must be twelve bits");
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  bts_pkg::bts_state_e state_q;  // run or discard slot
  bts_pkg::bts_kind_e  kind;     // decoded class
  logic                bit_val;  // selected bit value
  logic                cond;     // skip condition met
  bts_rd_if            rd ();    // read path to bit tester

  // classify a word by its top nibble
  function automatic bts_pkg::bts_kind_e classify(input logic [OP_W-1:0] w);
    logic [3:0] opc;
    opc = w[`BTS_OPC_HI:`BTS_OPC_LO];
    if (opc == `BTS_OPC_CLEAR)
      return bts_pkg::BTS_CLEAR; // RL6
    else if (opc == `BTS_OPC_SET)
      return bts_pkg::BTS_SET;   // RL6
    else
      return bts_pkg::BTS_OTHER;
  endfunction : classify

  assign kind        = classify(instr_word);
  // register address straight from the word, no banking
  assign reg_rd_addr = instr_word[`BTS_REG_HI:`BTS_REG_LO]; // RL5
  assign rd.rd_data  = reg_rd_data;
  assign rd.bit_sel  = instr_word[`BTS_BIT_HI:`BTS_BIT_LO];  // RL5
  assign bit_val     = rd.bit_val;

  // bit picker sits behind the shared read-path bundle
  bts_bit_sel i_bts_bit_sel
  (
    .rd (rd.tester)
  );

  // a test only counts when it really executes, not in a dead slot
  // gating on run keeps a discarded test from chaining a second skip
  always_comb
  begin
    cond = 1'h0;
    if (instr_valid && state_q == bts_pkg::BTS_RUN)
    begin
      unique case (kind)
        bts_pkg::BTS_CLEAR : cond = !bit_val; // RL1
        bts_pkg::BTS_SET   : cond = bit_val;  // RL2
        bts_pkg::BTS_OTHER : cond = 1'h0;
      endcase
    end
  end

  // ----------------------------------------
  // skip sequencing
  // ----------------------------------------
  // no fetch redirect: the next word simply executes as a no-op
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= bts_pkg::BTS_RUN;
    else if (state_q == bts_pkg::BTS_SKIP)
    begin
      if (instr_valid)
        state_q <= bts_pkg::BTS_RUN;  // RL4
    end
    else if (cond)
      state_q <= bts_pkg::BTS_SKIP;   // RL3
  end

  // ----------------------------------------
  // execute stage outputs
  // ----------------------------------------
  // registered so downstream sees a clean word per cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      exec_valid <= 1'h0;
      exec_word  <= `BTS_NOP_WORD;
      skip_taken <= 1'h0;
    end
    else
    begin
      exec_valid <= instr_valid;
      skip_taken <= cond;
      if (state_q == bts_pkg::BTS_SKIP)
        exec_word <= `BTS_NOP_WORD;   // RL3
      else
        exec_word <= instr_word;
    end
  end

  // tests never write status; flags_we is held low for every word
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flags_we <= 1'h0;
    else
      flags_we <= 1'h0;               // RL6
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_clear_hit;
    instr_valid && state_q == bts_pkg::BTS_RUN && kind == bts_pkg::BTS_CLEAR
      && !bit_val;
  endsequence
  sequence s_set_hit;
    instr_valid && state_q == bts_pkg::BTS_RUN && kind == bts_pkg::BTS_SET && bit_val;
  endsequence

  property p_clear_skip;
    @(posedge clk) disable iff (!arst_n) s_clear_hit |=> skip_taken;
  endproperty
  a_clear_skip: assert property (p_clear_skip) else $error("clear test missed skip"); // RL1

  property p_set_skip;
    @(posedge clk) disable iff (!arst_n) s_set_hit |=> skip_taken;
  endproperty
  a_set_skip: assert property (p_set_skip) else $error("set test missed skip"); // RL2

  property p_nop_slot;
    @(posedge clk) disable iff (!arst_n)
      (s_clear_hit or s_set_hit) ##1 instr_valid |=> exec_word == `BTS_NOP_WORD;
  endproperty
  a_nop_slot: assert property (p_nop_slot) else $error("skipped word not replaced"); // RL3

  property p_one_slot;
    @(posedge clk) disable iff (!arst_n)
      state_q == bts_pkg::BTS_SKIP && instr_valid |=> state_q == bts_pkg::BTS_RUN;
  endproperty
  a_one_slot: assert property (p_one_slot) else $error("skip lasted over one slot"); // RL4

  property p_no_false_skip;
    @(posedge clk) disable iff (!arst_n)
      instr_valid && kind == bts_pkg::BTS_OTHER |=> !skip_taken;
  endproperty
  a_no_false_skip: assert property (p_no_false_skip) else $error("skip from other word"); // RL6

  property p_addr;
    @(posedge clk) disable iff (!arst_n)
      reg_rd_addr == instr_word[4:0];
  endproperty
  a_addr: assert property (p_addr) else $error("register address mismatch"); // RL5

  property p_flags;
    @(posedge clk) disable iff (!arst_n) s_set_hit or s_clear_hit |=> !flags_we;
  endproperty
  a_flags: assert property (p_flags) else $error("status written by test"); // RL6

  property p_pass;
    @(posedge clk) disable iff (!arst_n)
      state_q == bts_pkg::BTS_RUN && instr_valid |=> exec_word == $past(instr_word);
  endproperty
  a_pass: assert property (p_pass) else $error("word not passed through"); // RL4

  // a met test raises the skip flag for one cycle only
  property p_pulse;
    @(posedge clk) disable iff (!arst_n) skip_taken |=> !skip_taken;
  endproperty
  a_pulse: assert property (p_pulse) else $error("skip flag held too long"); // RL4

  // unmet tests run straight on; named like the hits so the pairs read alike
  sequence s_clear_miss;
    instr_valid && state_q == bts_pkg::BTS_RUN && kind == bts_pkg::BTS_CLEAR
      && bit_val;
  endsequence
  sequence s_set_miss;
    instr_valid && state_q == bts_pkg::BTS_RUN && kind == bts_pkg::BTS_SET
      && !bit_val;
  endsequence

  property p_clear_go;
    @(posedge clk) disable iff (!arst_n) s_clear_miss |=> !skip_taken;
  endproperty
  a_clear_go: assert property (p_clear_go) else $error("clear test skipped"); // RL1

  property p_set_go;
    @(posedge clk) disable iff (!arst_n) s_set_miss |=> !skip_taken;
  endproperty
  a_set_go: assert property (p_set_go) else $error("set test skipped"); // RL2

  // gaps must not eat the pending slot, or the discarded word would run
  property p_slot_wait;
    @(posedge clk) disable iff (!arst_n)
      state_q == bts_pkg::BTS_SKIP && !instr_valid |=> state_q == bts_pkg::BTS_SKIP;
  endproperty
  a_slot_wait: assert property (p_slot_wait) else $error("skip slot lost in gap"); // RL3

  // the discarded word runs as a no-op and never tests, even after a gap
  property p_slot_nop;
    @(posedge clk) disable iff (!arst_n)
      state_q == bts_pkg::BTS_SKIP && instr_valid
      |=> exec_word == `BTS_NOP_WORD && !skip_taken;
  endproperty
  a_slot_nop: assert property (p_slot_nop) else $error("slot word not a no-op"); // RL3

  // valid follows the word one cycle late, skipped or not
  property p_valid;
    @(posedge clk) disable iff (!arst_n) 1'h1 |=> exec_valid == $past(instr_valid);
  endproperty
  a_valid: assert property (p_valid) else $error("valid not one cycle late"); // RL4
endmodule : bts_core

// *** test/bts_core_test.sv ***
// self-checking bench for the bit-test-and-skip block
`timescale 1ns/100ps
`include "bts_cfg.svh"
module bts_core_test;
  // ----------------------------------------
  // signals and bench state
  // ----------------------------------------
  logic        clk = 1'h0;          // 250 MHz core clock
  logic        arst_n = 1'h0;       // async reset, active low
  logic        instr_valid = 1'h0;  // word in execute
  logic [11:0] instr_word = 12'h000;
  logic [7:0]  reg_rd_data;         // file register answer
  logic [4:0]  reg_rd_addr;
  logic        exec_valid;
  logic [11:0] exec_word;
  logic        skip_taken;
  logic        flags_we;
  logic [7:0]  rf [32];             // bench copy of the file registers
  logic [13:0] notes [$];           // expected {valid, word, skip}
  logic        pend = 1'h0;         // next valid word is a discarded slot
  logic [31:0] seed = 32'h0000004b; // xorshift state
  int          failures = 0;
  int          n_compared = 0;

  always #2 clk = ~clk;
  // register file answers in the same cycle
  assign reg_rd_data = rf[reg_rd_addr];

  bts_core #(.OP_W(`BTS_OP_W)) i_bts_core
  (
    .clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .reg_rd_data(reg_rd_data),
    .reg_rd_addr(reg_rd_addr), .exec_valid(exec_valid),
    .exec_word(exec_word), .skip_taken(skip_taken), .flags_we(flags_we)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one word per falling edge; the note is written as it is driven
  task automatic drive(input logic v, input logic [11:0] w);
    logic hit;
    @(negedge clk);
    instr_valid = v;
    instr_word = w;
    hit = (w[11:8] == `BTS_OPC_CLEAR && !rf[w[4:0]][w[7:5]])
       || (w[11:8] == `BTS_OPC_SET && rf[w[4:0]][w[7:5]]);
    // gaps leave a pending skip slot untouched
    if (!v)
      notes.push_back(14'h0000);
    else if (pend)
    begin
      notes.push_back({1'h1, `BTS_NOP_WORD, 1'h0});
      pend = 1'h0;
    end
    else
    begin
      notes.push_back({1'h1, w, hit});
      pend = hit;
    end
    #1 check("rd_addr", {7'h00, reg_rd_addr}, {7'h00, w[4:0]});
  endtask : drive

  // reset held for three cycles, outputs cleared while held
  task automatic do_reset;
    @(negedge clk);
    arst_n = 1'h0;
    instr_valid = 1'h0;
    pend = 1'h0;
    #1 check("reset word", exec_word, `BTS_NOP_WORD);
    check("reset flags", {9'h000, exec_valid, skip_taken, flags_we}, 12'h000);
    repeat (3) @(negedge clk);
    arst_n = 1'h1;
  endtask : do_reset

  task automatic report_and_stop;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // output watcher: oldest note per cycle
  // ----------------------------------------
  always @(posedge clk)
  begin : watch
    logic [13:0] e;
    #1;
    if (notes.size() > 0)
    begin
      e = notes.pop_front();
      check("valid", {11'h000, exec_valid}, {11'h000, e[13]});
      if (e[13]) check("word", exec_word, e[12:1]);
      check("skip", {11'h000, skip_taken}, {11'h000, e[0]});
      check("flags_we", {11'h000, flags_we}, 12'h000);
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [11:0] w;
    for (int i = 0; i < 32; i++)
    begin
      seed = xs(seed);
      rf[i] = seed[7:0];
    end
    rf[0] = 8'hfe;   // bit 0 clear
    rf[31] = 8'h80;  // bit 7 set
    do_reset();
    // met test, gap, then a met test in the slot is ignored
    drive(1'h1, 12'h600);
    drive(1'h0, 12'h000);
    drive(1'h1, 12'h7ff);
    drive(1'h1, 12'h7ff);
    drive(1'h1, 12'h123);
    drive(1'h1, 12'h6ff);
    drive(1'h1, 12'h700);
    drive(1'h1, 12'h500); // neighbouring opcodes never skip
    drive(1'h1, 12'h4ff);
    // reset in mid-skip drops the pending slot
    drive(1'h1, 12'h600);
    do_reset();
    drive(1'h1, 12'h7ff);
    for (int i = 0; i < 600; i++)
    begin
      seed = xs(seed);
      w = {seed[1] ? {3'h3, seed[2]} : seed[11:8], seed[19:12]};
      drive(seed[24:22] != 3'h0, w);
    end
    drive(1'h0, 12'h000);
    for (int k = 0; k < 5 && notes.size() > 0; k++)
      @(negedge clk);
    if (notes.size() > 0) failures++;
    report_and_stop();
  end

  // hang guard
  initial
  begin
    #100000;
    failures++;
    report_and_stop();
  end
endmodule : bts_core_test
